// >>> src/ispc_pkg.sv
// Constants, register map and carrier types for the idle/stop power control block.
// Assumes a single 125 MHz APB clock domain.
package ispc_pkg;
	localparam int CLK_MHZ = 125;
	localparam int ADDR_W = 12;
	// Printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] POWER_CTRL_IDX = 8'h87;
	localparam logic [7:0] FLASH_TIMING_IDX = 8'hb6;
	localparam logic [7:0] WAKE_CFG_IDX = 8'hb0;
	localparam logic [7:0] STATUS_IDX = 8'hb1;
	localparam int IDLE_SEL_BIT = 0;
	localparam int STOP_SEL_BIT = 1;
	localparam int BYPASS_BIT = 6;
	localparam int WDT_EN_BIT = 0;
	localparam int MCD_EN_BIT = 1;
	localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
	localparam logic [7:0] FLASH_TIMING_RESET = 8'h00;
	localparam logic [7:0] FLASH_TIMING_MASK = 8'h40;
	localparam logic [7:0] WAKE_CFG_RESET = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	// Core is held in reset this long after any device reset request ends
	localparam int RESET_SEQ_NS = 80;
	localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] RESET_SEQ_LOAD = 8'(RESET_SEQ_CYCLES);

	typedef enum logic [2:0] {
		ISPC_RUN = 3'b001,
		ISPC_IDLE = 3'b010,
		ISPC_STOP = 3'b100
	} ispc_state_t;

	typedef struct packed {
		logic instr_done;
		logic irq_pending;
	} ispc_core_in_t;

	typedef struct packed {
		logic cpu_halt;
		logic irq_resume;
		logic core_reset;
		logic fetch_start;
		logic [15:0] fetch_addr;
	} ispc_core_out_t;

	typedef struct packed {
		logic periph_run;
		logic precise_osc_en;
		logic oneshot_bypass;
	} ispc_clk_out_t;

	function automatic logic [ADDR_W-1:0] ispc_byte_addr(input logic [7:0] idx);
		ispc_byte_addr = {2'b00, idx, 2'b00};
	endfunction
endpackage

// >>> src/ispc_sync.sv
// Two-flop level synchroniser for an asynchronous pin.
// Assumes the pin may change at any time relative to pclk.
`timescale 1ns/1ps
module ispc_sync import ispc_pkg::*; #(
	parameter logic RESET_VALUE = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;
	logic sync_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= RESET_VALUE;
			sync_reg <= RESET_VALUE;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

// >>> src/ispc_reset_seq.sv
// Ordinary reset sequence: holds the core in reset while a request stands
// and for a fixed count after it, then pulses the fetch start.
// Assumes the request is a level on pclk.
`timescale 1ns/1ps
module ispc_reset_seq import ispc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	output logic busy,
	output logic done
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic busy_reg;
	logic done_reg;

	assign cnt_next = req ? RESET_SEQ_LOAD : (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			busy_reg <= cnt_next != 8'h00;
			done_reg <= !req && cnt_reg == 8'h01;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
endmodule

// >>> src/ispc_power_ctrl.sv
// Idle and stop low-power control with flash read timing select, APB slave.
// Assumes the core reports instruction completion and pending enabled
// interrupts on pclk, and watchdog/missing-clock timeouts as pclk pulses.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps

// How it works
// - Setting the idle select bit halts the core only at the next instruction completion.
// - In idle the registers hold their values and peripherals keep their clock.
// - Idle ends on any enabled interrupt or any internal or external reset.
// - An interrupt wake clears the idle select bit and resumes the core to service it.
// - The core resumes at the instruction after the one that set idle, after the interrupt return.
// - A reset ending idle runs the reset sequence and fetches from address zero.
// - An enabled watchdog timeout issues an internal reset that ends idle.
// - Setting the stop select bit enters stop only at the next instruction completion.
// - Stop halts the core and the precision oscillator and leaves the other oscillators alone.
// - Only a reset ends stop, followed by the reset sequence and a fetch from address zero.
// - An enabled missing-clock timeout issues an internal reset that ends stop.
// - The bypass bit at 0 times flash reads by the one-shot, at 1 by the system clock.
// - Reserved flash timing bits read zero and software writes them as zero.
// - Clearing bypass takes effect at once with no padding instruction needed.
module ispc_power_ctrl import ispc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ispc_core_in_t core_in,
	input wire logic ext_reset_n,
	input wire logic wdt_timeout,
	input wire logic mcd_timeout,
	output ispc_core_out_t core_out,
	output ispc_clk_out_t clk_out
);
	ispc_state_t state_reg;
	ispc_state_t state_next;
	logic [7:0] power_ctrl_reg;
	logic [7:0] power_ctrl_next;
	logic [7:0] flash_timing_reg;
	logic [7:0] wake_cfg_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rdata_next;
	logic pready_reg;
	logic pslverr_reg;
	logic cpu_halt_reg;
	logic irq_resume_reg;
	logic precise_osc_reg;
	logic ext_rst_sync;
	logic seq_busy;
	logic seq_done;
	logic [7:0] hold_cnt_reg;

	wire access = psel && penable && pready_reg;
	wire wr_en = access && pwrite && pstrb[0];
	wire hit_power = paddr == ispc_byte_addr(POWER_CTRL_IDX);
	wire hit_flash = paddr == ispc_byte_addr(FLASH_TIMING_IDX);
	wire hit_cfg = paddr == ispc_byte_addr(WAKE_CFG_IDX);
	wire hit_status = paddr == ispc_byte_addr(STATUS_IDX);
	wire hit_any = hit_power || hit_flash || hit_cfg || hit_status;
	wire wr_power = wr_en && hit_power;
	wire wr_flash = wr_en && hit_flash;
	wire wr_cfg = wr_en && hit_cfg;
	wire wdt_fire = wdt_timeout && wake_cfg_reg[WDT_EN_BIT];
	wire mcd_fire = mcd_timeout && wake_cfg_reg[MCD_EN_BIT];
	// Any internal or external reset source, as a level on pclk
	wire dev_rst = !ext_rst_sync || wdt_fire || mcd_fire;
	wire idle_sel = power_ctrl_reg[IDLE_SEL_BIT];
	wire stop_sel = power_ctrl_reg[STOP_SEL_BIT];
	wire in_run = state_reg == ISPC_RUN;
	wire in_idle = state_reg == ISPC_IDLE;
	wire in_stop = state_reg == ISPC_STOP;
	wire irq_wake = in_idle && core_in.irq_pending && !dev_rst;
	wire [7:0] status_word = {3'b000, seq_busy, 1'b0, in_stop, in_idle, in_run};

	ispc_sync #(
		.RESET_VALUE(1'b1)
	) u_ext_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(ext_reset_n),
		.sync_out(ext_rst_sync)
	);

	ispc_reset_seq u_reset_seq (
		.pclk(pclk),
		.presetn(presetn),
		.req(dev_rst),
		.busy(seq_busy),
		.done(seq_done)
	);

	// Mode state: entry waits for the completing instruction, exits by cause
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ISPC_RUN: begin
				// Stop is the deeper mode, so it wins when both bits are set
				if (core_in.instr_done && stop_sel && !seq_busy) begin
					state_next = ISPC_STOP;
				end else if (core_in.instr_done && idle_sel && !seq_busy) begin
					state_next = ISPC_IDLE;
				end
			end
			ISPC_IDLE: begin
				if (core_in.irq_pending) begin
					state_next = ISPC_RUN;
				end
			end
			ISPC_STOP: begin
				state_next = ISPC_STOP;
			end
			default: begin
				state_next = ISPC_RUN;
			end
		endcase
		if (dev_rst) begin
			state_next = ISPC_RUN;
		end
	end

	// Software write wins over the hardware clear in the same cycle
	always_comb begin
		power_ctrl_next = power_ctrl_reg;
		if (irq_wake) begin
			power_ctrl_next[IDLE_SEL_BIT] = 1'b0;
		end
		if (wr_power) begin
			power_ctrl_next = {6'h00, pwdata[STOP_SEL_BIT], pwdata[IDLE_SEL_BIT]};
		end
		if (dev_rst) begin
			power_ctrl_next = POWER_CTRL_RESET;
		end
	end

	// Every register is eight bits wide; the upper read bits are always zero
	wire [31:0] power_word = {24'h00_0000, power_ctrl_reg};
	wire [31:0] flash_word = {24'h00_0000, flash_timing_reg};
	wire [31:0] cfg_word = {24'h00_0000, wake_cfg_reg};
	wire [31:0] status_rd_word = {24'h00_0000, status_word};
	assign rdata_next = !hit_any ? 32'h0000_0000 :
		hit_power ? power_word :
		hit_flash ? flash_word :
		hit_cfg ? cfg_word :
		status_rd_word;

	// No wait state: ready rises in the first access cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= psel && !penable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= psel && !penable && !hit_any;
		end
	end

	// Read data stands only in the access cycle, so a stale word never leaks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= (psel && !penable && !pwrite) ? rdata_next : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ISPC_RUN;
			power_ctrl_reg <= POWER_CTRL_RESET;
		end else begin
			state_reg <= state_next;
			power_ctrl_reg <= power_ctrl_next;
		end
	end

	// Only the bypass bit is stored, so reserved bits always read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_timing_reg <= FLASH_TIMING_RESET;
		end else if (dev_rst) begin
			flash_timing_reg <= FLASH_TIMING_RESET;
		end else if (wr_flash) begin
			flash_timing_reg <= pwdata[7:0] & FLASH_TIMING_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cfg_reg <= WAKE_CFG_RESET;
		end else if (wr_cfg) begin
			wake_cfg_reg <= {6'h00, pwdata[MCD_EN_BIT], pwdata[WDT_EN_BIT]};
		end
	end

	// Core and clock controls follow the next state so they change with it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_halt_reg <= 1'b0;
		end else begin
			cpu_halt_reg <= state_next != ISPC_RUN;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_resume_reg <= 1'b0;
		end else begin
			irq_resume_reg <= irq_wake;
		end
	end

	// The precision oscillator runs out of reset and stops only in stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			precise_osc_reg <= 1'b1;
		end else begin
			precise_osc_reg <= state_next != ISPC_STOP;
		end
	end

	// Cycles of core reset hold since the last request, for the length check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt_reg <= 8'h00;
		end else if (dev_rst || !seq_busy) begin
			hold_cnt_reg <= 8'h00;
		end else begin
			hold_cnt_reg <= hold_cnt_reg + 8'h01;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign core_out.cpu_halt = cpu_halt_reg;
	assign core_out.irq_resume = irq_resume_reg;
	assign core_out.core_reset = seq_busy;
	assign core_out.fetch_start = seq_done;
	assign core_out.fetch_addr = RESET_VECTOR;
	// Peripheral clock never stops in idle or stop; oscillators other than
	// the precision one are not driven from here at all
	assign clk_out.periph_run = 1'b1;
	assign clk_out.precise_osc_en = precise_osc_reg;
	assign clk_out.oneshot_bypass = flash_timing_reg[BYPASS_BIT];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_idle_armed;
		in_run && idle_sel && !stop_sel && !dev_rst && !seq_busy;
	endsequence
	sequence s_instr_done;
		core_in.instr_done;
	endsequence

	a_idle_entry_wait: assert property (s_idle_armed ##0 s_instr_done |=> in_idle && cpu_halt_reg)
		else $error("idle not entered after instruction completed");
	a_idle_no_early: assert property (in_run && !core_in.instr_done && !dev_rst |=> !in_idle)
		else $error("idle entered without instruction completion");
	a_idle_regs_hold: assert property (in_idle && !wr_en && !dev_rst |=> $stable(flash_timing_reg) && clk_out.periph_run)
		else $error("state changed while idle");
	a_irq_wake_clear: assert property (irq_wake && !wr_power |=> !idle_sel && in_run && !cpu_halt_reg)
		else $error("interrupt wake did not clear idle select");
	a_resume_pulse: assert property (irq_wake |=> irq_resume_reg ##1 !irq_resume_reg || irq_wake)
		else $error("resume pulse wrong");
	a_reset_sequence: assert property (dev_rst ##1 !dev_rst [*1] |-> seq_busy [*8])
		else $error("reset sequence too short");
	a_wdt_ends_idle: assert property (in_idle && wdt_timeout && wake_cfg_reg[WDT_EN_BIT] |=> in_run && power_ctrl_reg == 8'h00)
		else $error("watchdog did not end idle");
	a_stop_entry: assert property (in_run && stop_sel && core_in.instr_done && !dev_rst && !seq_busy
		|=> in_stop && !clk_out.precise_osc_en && cpu_halt_reg)
		else $error("stop entry wrong");
	a_stop_no_irq: assert property (in_stop && !dev_rst |=> in_stop)
		else $error("stop left without reset");
	a_mcd_ends_stop: assert property (in_stop && mcd_timeout && wake_cfg_reg[MCD_EN_BIT] |=> in_run ##1 core_out.core_reset)
		else $error("missing clock did not end stop");
	a_bypass_follows: assert property (wr_flash && !dev_rst |=> clk_out.oneshot_bypass == $past(pwdata[BYPASS_BIT]))
		else $error("bypass did not follow write");
	a_reserved_zero: assert property ((flash_timing_reg & ~FLASH_TIMING_MASK) == 8'h00)
		else $error("reserved flash timing bit set");
	a_fetch_zero: assert property (seq_done |-> core_out.fetch_addr == 16'h0000 && !seq_busy)
		else $error("fetch not from address zero");

	sequence s_reset_req;
		dev_rst;
	endsequence
	sequence s_busy_end;
		$fell(seq_busy);
	endsequence
	sequence s_idle_wake;
		in_idle ##1 in_run;
	endsequence
	sequence s_mode_entry;
		in_run ##1 !in_run;
	endsequence

	a_reset_hold_len: assert property (s_busy_end |-> hold_cnt_reg == RESET_SEQ_LOAD && seq_done)
		else $error("reset hold length wrong");
	a_fetch_one_pulse: assert property (seq_done |=> !core_out.fetch_start)
		else $error("fetch start longer than one cycle");
	a_req_clears_sel: assert property (s_reset_req |=> power_ctrl_reg == POWER_CTRL_RESET && in_run && !cpu_halt_reg)
		else $error("reset did not clear mode select");
	a_req_holds_core: assert property (s_reset_req |=> core_out.core_reset)
		else $error("reset request did not hold the core");
	a_req_clears_flash: assert property (s_reset_req |=> flash_timing_reg == FLASH_TIMING_RESET)
		else $error("reset did not clear flash timing");
	a_wake_cause: assert property (s_idle_wake |-> $past(core_in.irq_pending) || $past(dev_rst))
		else $error("idle left without interrupt or reset");
	a_mode_entry_done: assert property (s_mode_entry |-> $past(core_in.instr_done))
		else $error("low power entered without instruction completion");
	a_resume_cause: assert property (irq_resume_reg |-> $past(irq_wake))
		else $error("resume without interrupt wake");
	a_idle_sel_hold: assert property (in_idle && !irq_wake && !wr_power && !dev_rst |=> $stable(power_ctrl_reg))
		else $error("power control changed while idle");
	a_idle_irq_exit: assert property (in_idle && core_in.irq_pending |=> in_run)
		else $error("pending interrupt did not end idle");
	a_stop_no_early: assert property (in_run && !core_in.instr_done && !dev_rst |=> !in_stop)
		else $error("stop entered without instruction completion");
	a_stop_keeps_sel: assert property (in_stop && !dev_rst && !wr_power |=> stop_sel)
		else $error("stop select lost in stop");
	a_halt_follows: assert property (cpu_halt_reg == !in_run)
		else $error("halt does not match mode");
	a_osc_follows: assert property (clk_out.precise_osc_en == !in_stop)
		else $error("precision oscillator enable does not match mode");
	a_periph_always: assert property (clk_out.periph_run)
		else $error("peripheral clock stopped");
	a_bypass_clear_now: assert property (wr_flash && !dev_rst && !pwdata[BYPASS_BIT] |=> !clk_out.oneshot_bypass)
		else $error("bypass clear not immediate");
	a_bypass_hold: assert property (!wr_flash && !dev_rst |=> $stable(clk_out.oneshot_bypass))
		else $error("bypass changed without write");
	a_cfg_survives: assert property (dev_rst && !wr_cfg |=> $stable(wake_cfg_reg))
		else $error("reset source enables lost on reset");
	a_read_upper_zero: assert property (pready_reg |-> prdata_reg[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
endmodule

// >>> verification/ispc_core_model.sv
// Behavioural model of the core side: instruction completion and one enabled interrupt.
// Assumes the bench raises one-cycle requests by non-blocking assignment on pclk.
`timescale 1ns/1ps
module ispc_core_model import ispc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic done_req,
	input wire logic irq_req,
	input wire ispc_core_out_t core_out,
	output ispc_core_in_t core_in
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_in <= '0;
		end else begin
			// A core held in reset completes nothing
			core_in.instr_done <= done_req && !core_out.core_reset;
			// Pending stays until serviced or reset, so a stop sees it for a long time
			if (core_out.irq_resume || core_out.core_reset) begin
				core_in.irq_pending <= 1'b0;
			end else if (irq_req) begin
				core_in.irq_pending <= 1'b1;
			end
		end
	end
endmodule

// >>> verification/test_idle_stop_power_control.sv
// Self-checking bench for the idle/stop power control block.
// Assumes the core model is compiled first; APB reads are checked from a queue.
`timescale 1ns/1ps
module test_idle_stop_power_control import ispc_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic ext_reset_n = 1, wdt_timeout = 0, mcd_timeout = 0, done_req = 0, irq_req = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pstrb = '0;
	ispc_core_in_t core_in;
	ispc_core_out_t core_out;
	ispc_clk_out_t clk_out;
	logic [32:0] exp_q[$];
	logic [32:0] mon_e;
	logic [31:0] lfsr = 32'h00011cd3;
	int fail_count = 0, compares = 0, cyc = 0, rc;
	always #4 pclk = ~pclk;
	ispc_power_ctrl ispc_power_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_in(core_in), .ext_reset_n(ext_reset_n), .wdt_timeout(wdt_timeout),
		.mcd_timeout(mcd_timeout), .core_out(core_out), .clk_out(clk_out));
	ispc_core_model ispc_core_model_i (.pclk(pclk), .presetn(presetn), .done_req(done_req),
		.irq_req(irq_req), .core_out(core_out), .core_in(core_in));
	function automatic logic [31:0] next_rand(input logic [31:0] v);
		next_rand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic end_of_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s,
		input logic [32:0] e);
		exp_q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input int k);
		@(posedge pclk);
		case (k)
			0: done_req <= 1'b1;
			1: irq_req <= 1'b1;
			2: wdt_timeout <= 1'b1;
			3: mcd_timeout <= 1'b1;
			default: ext_reset_n <= 1'b0;
		endcase
		@(posedge pclk);
		{done_req, irq_req, wdt_timeout, mcd_timeout, ext_reset_n} <= 5'h01;
	endtask
	task automatic enter(input logic [7:0] v);
		apb(1, POWER_CTRL_IDX, {24'h0, v}, 4'h1, 33'h0);
		@(negedge pclk);
		chk("halt early", 32'h0, 32'(core_out.cpu_halt));
		pulse(0);
		repeat (4) @(negedge pclk);
		chk("halt", 32'h1, 32'(core_out.cpu_halt));
	endtask
	task automatic wait_fetch;
		int n;
		n = 0;
		rc = 0;
		while (n < 60 && core_out.fetch_start !== 1'b1) begin
			@(negedge pclk);
			n++;
			if (core_out.core_reset === 1'b1) rc++;
		end
		chk("fetch_start", 32'h1, 32'(core_out.fetch_start));
		chk("fetch_addr", 32'h0, 32'(core_out.fetch_addr));
		chk("halt", 32'h0, 32'(core_out.cpu_halt));
		apb(0, POWER_CTRL_IDX, 32'h0, 4'h0, 33'h0);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			mon_e = exp_q.pop_front();
			chk("pslverr", 32'(mon_e[32]), 32'(pslverr));
			if (!pwrite) chk("prdata", mon_e[31:0], prdata);
		end
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, FLASH_TIMING_IDX, 32'h0, 4'h0, 33'h0);
		apb(0, STATUS_IDX, 32'h0, 4'h0, 33'h1);
		apb(0, 8'h12, 32'h0, 4'h0, 33'h100000000);
		chk("osc", 32'h1, 32'(clk_out.precise_osc_en));
		for (int i = 0; i < 4; i++) begin
			lfsr = next_rand(lfsr);
			apb(1, FLASH_TIMING_IDX, lfsr & 32'h40, 4'h1, 33'h0);
			@(negedge pclk);
			chk("bypass", 32'(lfsr[6]), 32'(clk_out.oneshot_bypass));
			apb(0, FLASH_TIMING_IDX, 32'h0, 4'h0, {1'b0, lfsr & 32'h40});
		end
		// Fast clock: bypass on; reserved bits always written as zero
		apb(1, FLASH_TIMING_IDX, 32'h40, 4'h1, 33'h0);
		apb(0, FLASH_TIMING_IDX, 32'h0, 4'h0, 33'h40);
		apb(1, FLASH_TIMING_IDX, 32'h0, 4'h0, 33'h0);
		apb(0, FLASH_TIMING_IDX, 32'h0, 4'h0, 33'h40);
		apb(1, FLASH_TIMING_IDX, 32'h0, 4'h1, 33'h0);
		apb(0, FLASH_TIMING_IDX, 32'h0, 4'h0, 33'h0);
		enter(8'h01);
		apb(0, STATUS_IDX, 32'h0, 4'h0, 33'h2);
		chk("periph", 32'h1, 32'(clk_out.periph_run));
		pulse(1);
		repeat (2) @(negedge pclk);
		chk("resume", 32'h1, 32'(core_out.irq_resume));
		@(negedge pclk);
		chk("halt", 32'h0, 32'(core_out.cpu_halt));
		chk("resume end", 32'h0, 32'(core_out.irq_resume));
		chk("reset", 32'h0, 32'(core_out.core_reset));
		apb(0, POWER_CTRL_IDX, 32'h0, 4'h0, 33'h0);
		apb(1, WAKE_CFG_IDX, 32'h1, 4'h1, 33'h0);
		enter(8'h01);
		pulse(2);
		wait_fetch();
		chk("seq len", 32'(RESET_SEQ_CYCLES), 32'(rc));
		apb(1, WAKE_CFG_IDX, 32'h2, 4'h1, 33'h0);
		enter(8'h02);
		chk("osc", 32'h0, 32'(clk_out.precise_osc_en));
		pulse(1);
		pulse(2);
		repeat (4) @(negedge pclk);
		chk("halt", 32'h1, 32'(core_out.cpu_halt));
		chk("resume", 32'h0, 32'(core_out.irq_resume));
		pulse(3);
		wait_fetch();
		chk("seq len", 32'(RESET_SEQ_CYCLES), 32'(rc));
		chk("osc", 32'h1, 32'(clk_out.precise_osc_en));
		enter(8'h01);
		pulse(4);
		wait_fetch();
		chk("seq len", 32'(RESET_SEQ_CYCLES), 32'(rc));
		end_of_test();
	end
endmodule
